// *** rtl/uamc_line_watch.sv ***
// Purpose: synchronise the modem inputs and detect their changes
// Assumes: pins are asynchronous to core_clk
// Notes:   ri reports only its rising (active-high) edge
`timescale 1ns/1ps
module uamc_line_watch
  import uamc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // modem pins, active low
  input  wire logic [3:0] line_n,
  // loopback
  input  wire logic       loop_en,
  input  wire logic [3:0] loop_src,
  // toward the core
  uamc_mdm_if.watch       mdm
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] prev;
    logic [3:0] chg;
  } uamc_watch_t;

  uamc_watch_t st;
  uamc_watch_t next_st;
  logic [3:0]  live;

  // ---------------------------------------------------------------
  // sampling and change detection
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st    = st;
    next_st.s1 = line_n;
    next_st.s2 = st.s1;
    live       = loop_en ? loop_src : ~st.s2;
    next_st.prev = live;
    next_st.chg  = live ^ st.prev;
    next_st.chg[2] = live[2] & ~st.prev[2];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    // synchroniser starts at the idle (high) pin level so no false change follows reset
    if (!rst_n)
      st <= '{s1: '1, s2: '1, default: '0};
    else
      st <= next_st;
  end

  assign mdm.level  = st.prev;
  assign mdm.change = st.chg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_ri_rise_only: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    st.chg[2] |-> (st.prev[2] && !$past(st.prev[2])))
    else $error("ri change flagged without a rising edge");

  a_cts_change_seen: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (st.prev[0] != $past(st.prev[0])) |-> st.chg[0])
    else $error("cts change not flagged");

endmodule : uamc_line_watch

// *** rtl/uamc_mdm_if.sv ***
// Purpose: carries modem input levels and change events between modules
// Assumes: bit order cts, dsr, ri, cd
// Notes:   levels are active high, changes are one-cycle pulses
`timescale 1ns/1ps
interface uamc_mdm_if;
  logic [3:0] level;
  logic [3:0] change;
  modport watch (output level, output change);
  modport core  (input level, input change);
endinterface : uamc_mdm_if

// *** rtl/uamc_modem_irq.sv ***
// Purpose: modem control, modem status and interrupt enable/identification
// Assumes: one-cycle read and write strobes on core_clk, sources are level inputs
// Notes:   read data appear one cycle after the read strobe
`timescale 1ns/1ps
module uamc_modem_irq
  import uamc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // modem pins, active low
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       ri_n,
  input  wire logic       cd_n,
  output logic            dtr_n,
  output logic            rts_n,
  output logic            gen_out_n,
  // interrupt pin
  output logic            irq,
  output logic            irq_oe,
  // from the rest of the channel
  input  wire logic       enh_enable,
  input  wire logic       fifo_enable,
  input  wire logic       auto_rts_en,
  input  wire logic       auto_rts_n,
  input  wire logic       lsr_error,
  input  wire logic       rx_timeout,
  input  wire logic       rx_ready,
  input  wire logic       tx_space_ok,
  input  wire logic       tx_write,
  input  wire logic       xoff_seen,
  // to the rest of the channel
  output logic            loop_en,
  output logic            fifo_rdy_en,
  output logic            xon_any_en,
  output logic            thresh_access,
  output logic            sleep_en,
  output logic            presc_tick
);

  typedef struct packed {
    logic [7:0] modem_line_control;
    logic [7:0] interrupt_enables;
    logic [3:0] delta;
    logic       xoff_flag;
    logic       chg_flag;
    logic       thr_flag;
    logic       tx_ok_d;
    logic       rts_d;
    logic       cts_d;
    logic [1:0] presc;
    logic       tick;
    logic [7:0] rdata;
  } uamc_core_t;

  uamc_core_t st;
  uamc_core_t next_st;
  uamc_mdm_if mdm ();

  logic [3:0] loop_src;
  logic [7:0] msr_view;
  logic [5:0] id_code;
  logic       pend;
  logic       wr_mcr;
  logic       wr_ier;
  logic       rd_msr;
  logic       rd_iir;

  // merge a write into a register, upper bits kept unless enhanced enable
  function automatic logic [7:0] uamc_merge(input logic [7:0] cur,
                                            input logic [7:0] wd,
                                            input logic [7:0] lock,
                                            input logic       enh);
    logic [7:0] keep;
    keep = enh ? 8'h00 : lock;
    return (cur & keep) | (wd & ~keep);
  endfunction : uamc_merge

  // ---------------------------------------------------------------
  // modem input watcher
  // ---------------------------------------------------------------
  // loopback sources in cts, dsr, ri, cd order
  assign loop_src = {st.modem_line_control[UAMC_MCR_OUT], st.modem_line_control[UAMC_MCR_RDY],
                     st.modem_line_control[UAMC_MCR_DTR], st.modem_line_control[UAMC_MCR_RTS]};

  uamc_line_watch uamc_line_watch_inst (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .line_n   ({cd_n, ri_n, dsr_n, cts_n}),
    .loop_en  (st.modem_line_control[UAMC_MCR_LOOP]),
    .loop_src (loop_src),
    .mdm      (mdm.watch)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  always_comb
  begin
    wr_mcr = 1'b0;
    wr_ier = 1'b0;
    rd_msr = 1'b0;
    rd_iir = 1'b0;
    if (reg_wr && reg_addr == UAMC_OFS_MCR)
      wr_mcr = 1'b1;
    else if (reg_wr && reg_addr == UAMC_OFS_IER)
      wr_ier = 1'b1;
    else if (reg_rd && reg_addr == UAMC_OFS_MSR)
      rd_msr = 1'b1;
    else if (reg_rd && reg_addr == UAMC_OFS_IIR)
      rd_iir = 1'b1;
  end

  // ---------------------------------------------------------------
  // status view and interrupt priority
  // ---------------------------------------------------------------
  always_comb
  begin
    msr_view = {mdm.level[3], mdm.level[2], mdm.level[1], mdm.level[0],
                st.delta};
    id_code  = UAMC_ID_NONE;
    // lowest priority first so that later tests win
    if (st.chg_flag && (st.interrupt_enables[UAMC_IER_RTS] || st.interrupt_enables[UAMC_IER_CTS]))
      id_code = UAMC_ID_CHG;
    if (st.xoff_flag && st.interrupt_enables[UAMC_IER_XOFF])
      id_code = UAMC_ID_XOFF;
    if (st.delta != 4'h0 && st.interrupt_enables[UAMC_IER_MDM])
      id_code = UAMC_ID_MDM;
    if (st.thr_flag && st.interrupt_enables[UAMC_IER_THR])
      id_code = UAMC_ID_THR;
    if (rx_ready && st.interrupt_enables[UAMC_IER_RHR])
      id_code = UAMC_ID_RHR;
    if (rx_timeout && st.interrupt_enables[UAMC_IER_RHR])
      id_code = UAMC_ID_RTO;
    if (lsr_error && st.interrupt_enables[UAMC_IER_LSR])
      id_code = UAMC_ID_LSR;
    pend = (id_code != UAMC_ID_NONE);
  end

  // ---------------------------------------------------------------
  // state update
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    if (wr_mcr)
      next_st.modem_line_control = uamc_merge(st.modem_line_control, reg_wdata, UAMC_ENH_MASK, enh_enable);
    if (wr_ier)
      next_st.interrupt_enables = uamc_merge(st.interrupt_enables, reg_wdata, UAMC_IEN_MASK, enh_enable);
    // status deltas: a read clears, a change in the same cycle still sets
    if (rd_msr)
      next_st.delta = 4'h0;
    next_st.delta = next_st.delta | mdm.change;
    // xoff and line change flags clear on an identification read that reports them
    if (rd_iir && id_code == UAMC_ID_XOFF)
      next_st.xoff_flag = 1'b0;
    if (xoff_seen)
      next_st.xoff_flag = 1'b1;
    if (rd_iir && id_code == UAMC_ID_CHG)
      next_st.chg_flag = 1'b0;
    next_st.rts_d = rts_n;
    next_st.cts_d = mdm.level[0];
    // active to inactive means cts level falling or rts pin rising
    if ((rts_n && !st.rts_d && st.interrupt_enables[UAMC_IER_RTS]) ||
        (!mdm.level[0] && st.cts_d && st.interrupt_enables[UAMC_IER_CTS]))
      next_st.chg_flag = 1'b1;
    // transmit flag fires on the threshold edge only, not on re-enable
    next_st.tx_ok_d = tx_space_ok;
    if (tx_write || (rd_iir && id_code == UAMC_ID_THR))
      next_st.thr_flag = 1'b0;
    if (tx_space_ok && !st.tx_ok_d)
      next_st.thr_flag = 1'b1;
    // prescaler enable
    if (!st.modem_line_control[UAMC_MCR_DIV4] || st.presc == UAMC_DIV4_LAST)
      next_st.presc = 2'h0;
    else
      next_st.presc = st.presc + 2'h1;
    next_st.tick = !st.modem_line_control[UAMC_MCR_DIV4] || st.presc == UAMC_DIV4_LAST;
    // read data
    next_st.rdata = 8'h00;
    if (reg_rd && reg_addr == UAMC_OFS_MCR)
      next_st.rdata = st.modem_line_control;
    else if (reg_rd && reg_addr == UAMC_OFS_IER)
      next_st.rdata = st.interrupt_enables;
    else if (rd_msr)
      next_st.rdata = msr_view;
    else if (rd_iir)
      next_st.rdata = {fifo_enable, fifo_enable, id_code};
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st     <= '0;
      st.modem_line_control <= UAMC_MCR_RST;
      st.interrupt_enables <= UAMC_IER_RST;
    end
    else
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata     = st.rdata;
  assign dtr_n         = ~st.modem_line_control[UAMC_MCR_DTR];
  assign rts_n         = auto_rts_en ? auto_rts_n : ~st.modem_line_control[UAMC_MCR_RTS];
  assign gen_out_n     = ~st.modem_line_control[UAMC_MCR_OUT];
  assign irq_oe        = st.modem_line_control[UAMC_MCR_OUT];
  assign irq           = st.modem_line_control[UAMC_MCR_OUT] & pend;
  assign loop_en       = st.modem_line_control[UAMC_MCR_LOOP];
  assign fifo_rdy_en   = st.modem_line_control[UAMC_MCR_RDY];
  assign xon_any_en    = st.modem_line_control[UAMC_MCR_XANY];
  assign thresh_access = st.modem_line_control[UAMC_MCR_TCRA];
  assign sleep_en      = st.interrupt_enables[UAMC_IER_SLP];
  assign presc_tick    = st.tick;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_dtr_after_write: assert property (
    wr_mcr |=> dtr_n == !$past(reg_wdata[UAMC_MCR_DTR]))
    else $error("dtr does not follow control write");

  a_rts_auto_path: assert property (
    auto_rts_en |-> rts_n == auto_rts_n)
    else $error("rts not under flow control");

  a_mcr_upper_lock: assert property (
    (wr_mcr && !enh_enable) |=> st.modem_line_control[7:5] == $past(st.modem_line_control[7:5]))
    else $error("locked control bits changed");

  a_ier_upper_lock: assert property (
    (wr_ier && !enh_enable) |=> st.interrupt_enables[7:4] == $past(st.interrupt_enables[7:4]))
    else $error("locked enable bits changed");

  a_msr_read_clear: assert property (
    (rd_msr && mdm.change == 4'h0) |=> st.delta == 4'h0)
    else $error("status deltas not cleared by read");

  // an independent sum of enabled sources, kept apart from the priority chain
  a_irq_gated: assert property (
    irq == (irq_oe &&
            ((lsr_error && st.interrupt_enables[UAMC_IER_LSR]) ||
             ((rx_ready || rx_timeout) && st.interrupt_enables[UAMC_IER_RHR]) ||
             (st.thr_flag && st.interrupt_enables[UAMC_IER_THR]) ||
             (st.delta != 4'h0 && st.interrupt_enables[UAMC_IER_MDM]) ||
             (st.xoff_flag && st.interrupt_enables[UAMC_IER_XOFF]) ||
             (st.chg_flag && (st.interrupt_enables[UAMC_IER_RTS] || st.interrupt_enables[UAMC_IER_CTS])))))
    else $error("interrupt output does not match enabled sources");

  a_oe_tristate: assert property (
    !irq_oe |-> !irq)
    else $error("interrupt driven while output disabled");

  a_iir_fifo_mirror: assert property (
    rd_iir |=> reg_rdata[7:6] == {2{$past(fifo_enable)}})
    else $error("identification upper bits do not mirror fifo enable");

  a_iir_read_only: assert property (
    (reg_wr && reg_addr == UAMC_OFS_IIR) |=> $stable(st.modem_line_control) && $stable(st.interrupt_enables))
    else $error("identification write changed a register");

  a_rts_change_flag: assert property (
    ($rose(rts_n) && st.interrupt_enables[UAMC_IER_RTS]) |=> st.chg_flag)
    else $error("rts rising change not flagged");

  a_xoff_set_wins: assert property (
    xoff_seen |=> st.xoff_flag)
    else $error("xoff event lost");

  a_loop_view: assert property (
    (loop_en && $stable(st.modem_line_control)) [*3] |-> msr_view[4] == st.modem_line_control[UAMC_MCR_RTS])
    else $error("loopback status does not follow control");

  a_lsr_first: assert property (
    (lsr_error && st.interrupt_enables[UAMC_IER_LSR]) |-> id_code == UAMC_ID_LSR)
    else $error("line status not highest priority");

  a_presc_div4: assert property (
    (st.modem_line_control[UAMC_MCR_DIV4] && $stable(st.modem_line_control[UAMC_MCR_DIV4]) && presc_tick)
      |=> (!presc_tick || !$past(st.modem_line_control[UAMC_MCR_DIV4])) [*3])
    else $error("prescaler tick too frequent");

  a_thr_no_refire: assert property (
    ($rose(st.interrupt_enables[UAMC_IER_THR]) && !st.thr_flag && tx_space_ok && st.tx_ok_d)
      |=> !st.thr_flag)
    else $error("re-enable raised transmit interrupt");

  a_mdm_irq: assert property (
    (st.delta != 4'h0 && st.interrupt_enables[UAMC_IER_MDM] && !lsr_error && !rx_ready &&
     !rx_timeout && !st.thr_flag) |-> id_code == UAMC_ID_MDM)
    else $error("modem interrupt missing");

  c_loopback_change: cover property (loop_en ##1 mdm.change != 4'h0);
  c_irq_raised:      cover property (!irq ##1 irq);
  c_msr_cleared:     cover property (st.delta != 4'h0 ##1 rd_msr ##1 st.delta == 4'h0);
  c_chg_flag:        cover property ($rose(st.chg_flag));

endmodule : uamc_modem_irq

// *** rtl/uamc_pkg.sv ***
// Purpose: shared constants for the modem control and interrupt block
// Assumes: 3-bit register address, 8-bit register data
// Notes:   interrupt codes hold identification bits 5:0
package uamc_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] UAMC_OFS_IER = 3'h1;
  localparam logic [2:0] UAMC_OFS_IIR = 3'h2;
  localparam logic [2:0] UAMC_OFS_MCR = 3'h4;
  localparam logic [2:0] UAMC_OFS_MSR = 3'h6;

  // ---------------------------------------------------------------
  // field positions and masks
  // ---------------------------------------------------------------
  localparam int UAMC_MCR_DTR  = 0;
  localparam int UAMC_MCR_RTS  = 1;
  localparam int UAMC_MCR_RDY  = 2;
  localparam int UAMC_MCR_OUT  = 3;
  localparam int UAMC_MCR_LOOP = 4;
  localparam int UAMC_MCR_XANY = 5;
  localparam int UAMC_MCR_TCRA = 6;
  localparam int UAMC_MCR_DIV4 = 7;
  localparam int UAMC_IER_RHR  = 0;
  localparam int UAMC_IER_THR  = 1;
  localparam int UAMC_IER_LSR  = 2;
  localparam int UAMC_IER_MDM  = 3;
  localparam int UAMC_IER_SLP  = 4;
  localparam int UAMC_IER_XOFF = 5;
  localparam int UAMC_IER_RTS  = 6;
  localparam int UAMC_IER_CTS  = 7;
  localparam logic [7:0] UAMC_ENH_MASK = 8'hE0;
  localparam logic [7:0] UAMC_IEN_MASK = 8'hF0;

  // ---------------------------------------------------------------
  // reset values and interrupt codes
  // ---------------------------------------------------------------
  localparam logic [7:0] UAMC_MCR_RST = 8'h00;
  localparam logic [7:0] UAMC_IER_RST = 8'h00;
  localparam logic [5:0] UAMC_ID_NONE = 6'h01;
  localparam logic [5:0] UAMC_ID_LSR  = 6'h06;
  localparam logic [5:0] UAMC_ID_RTO  = 6'h0C;
  localparam logic [5:0] UAMC_ID_RHR  = 6'h04;
  localparam logic [5:0] UAMC_ID_THR  = 6'h02;
  localparam logic [5:0] UAMC_ID_MDM  = 6'h00;
  localparam logic [5:0] UAMC_ID_XOFF = 6'h10;
  localparam logic [5:0] UAMC_ID_CHG  = 6'h20;
  localparam logic [1:0] UAMC_DIV4_LAST = 2'h3;

endpackage : uamc_pkg

// *** verification/uamc_modem_peer.sv ***
// Purpose: behavioural modem on the far side of the control lines
// Assumes: the bench sets the line levels by task calls off the clock edge
// Notes:   idle lines rest inactive (high), as a pulled-up cable would
`timescale 1ns/1ps
module uamc_modem_peer
(
  // from the device
  input  wire logic dtr_n,
  input  wire logic rts_n,
  // to the device, active low
  output logic      cts_n,
  output logic      dsr_n,
  output logic      ri_n,
  output logic      cd_n
);
  // ------------------------------------------------------------
  // line levels, active-high view: cd, ri, dsr, cts
  // ------------------------------------------------------------
  logic [3:0] lines = 4'h0;

  assign {cd_n, ri_n, dsr_n, cts_n} = ~lines;

  task automatic set_lines(input logic [3:0] v);
    lines = v;
  endtask : set_lines
endmodule : uamc_modem_peer

// *** verification/uart_modem_ctrl_irq_tb.sv ***
// Purpose: self-checking bench for the modem control and interrupt block
// Assumes: inputs change on the falling edge; reads are checked from a queue
// Notes:   each read pushes {mask, expected}; the monitor pops one per result
`timescale 1ns/1ps
module uart_modem_ctrl_irq_tb;
  import uamc_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        core_clk, rst_n, reg_wr, reg_rd, rd_d;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, pins, n;
  logic        cts_n, dsr_n, ri_n, cd_n, dtr_n, rts_n, gen_out_n, irq, irq_oe;
  logic        enh_enable, fifo_enable, auto_rts_en, auto_rts_n, lsr_error;
  logic        rx_timeout, rx_ready, tx_space_ok, tx_write, xoff_seen;
  logic        loop_en, fifo_rdy_en, xon_any_en, thresh_access, sleep_en, presc_tick;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [3:0]  r;
  int          error_cnt, compares, cyc;
  int          seed = 32'h7455;

  assign pins = {dtr_n, rts_n, gen_out_n, irq, irq_oe, loop_en, fifo_rdy_en, xon_any_en};

  uamc_modem_irq uamc_modem_irq_inst (
    .core_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .cts_n, .dsr_n, .ri_n, .cd_n, .dtr_n, .rts_n, .gen_out_n, .irq, .irq_oe,
    .enh_enable, .fifo_enable, .auto_rts_en, .auto_rts_n, .lsr_error, .rx_timeout,
    .rx_ready, .tx_space_ok, .tx_write, .xoff_seen, .loop_en, .fifo_rdy_en,
    .xon_any_en, .thresh_access, .sleep_en, .presc_tick
  );

  uamc_modem_peer uamc_modem_peer_inst (
    .dtr_n, .rts_n, .cts_n, .dsr_n, .ri_n, .cd_n
  );

  // ------------------------------------------------------------
  // clock, timeout, checking
  // ------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // the whole run needs well under 1000 cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // read data stands one cycle after the strobe, so sample it mid-cycle
  always @(posedge core_clk) rd_d <= reg_rd;
  always @(negedge core_clk)
    if (rd_d === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check(reg_rdata & e[15:8], e[7:0]);
    end

  // ------------------------------------------------------------
  // bus tasks; a spare cycle keeps strobes from being re-raised in one step
  // ------------------------------------------------------------
  task automatic idle(input int k);
    repeat (k) @(negedge core_clk);
  endtask : idle

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    idle(1);
    reg_wr    = 1'b0;
    idle(1);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] x, input logic [7:0] m);
    exp_q.push_back({m, x & m});
    reg_addr = a;
    reg_rd   = 1'b1;
    idle(1);
    reg_rd   = 1'b0;
    idle(1);
  endtask : rd

  // pins need 4 edges to reach the status flags
  task automatic lines(input logic [3:0] v);
    uamc_modem_peer_inst.set_lines(v);
    idle(6);
  endtask : lines

  task automatic ticks();
    n = 8'h00;
    repeat (8)
    begin
      idle(1);
      n = n + {7'h00, presc_tick};
    end
  endtask : ticks

  task automatic end_of_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {enh_enable, fifo_enable, auto_rts_en, lsr_error, rx_timeout} = '0;
    {rx_ready, tx_space_ok, tx_write, xoff_seen} = '0;
    auto_rts_n = 1'b1;
    repeat (4) @(posedge core_clk);
    idle(1);
    rst_n = 1'b1;
    check(pins, 8'hE0);
    rd(UAMC_OFS_MCR, 8'h00, 8'hFF);
    rd(UAMC_OFS_IER, 8'h00, 8'hFF);
    rd(UAMC_OFS_IIR, 8'h01, 8'hFF);
    rd(3'h0, 8'h00, 8'hFF);
    rd(UAMC_OFS_MSR, 8'h00, 8'hFF);
    $display("done: reset");
    wr(UAMC_OFS_IER, 8'hFF);
    rd(UAMC_OFS_IER, 8'h0F, 8'hFF);
    wr(UAMC_OFS_MCR, 8'hEF);
    rd(UAMC_OFS_MCR, 8'h0F, 8'hFF);
    check(pins, 8'h0A);
    enh_enable = 1'b1;
    wr(UAMC_OFS_MCR, 8'hE0);
    rd(UAMC_OFS_MCR, 8'hE0, 8'hFF);
    check(pins, 8'hE1);
    wr(UAMC_OFS_IER, 8'hF0);
    rd(UAMC_OFS_IER, 8'hF0, 8'hFF);
    check({6'h00, thresh_access, sleep_en}, 8'h03);
    ticks();
    check(n, 8'h02);
    wr(UAMC_OFS_MCR, 8'h04);
    ticks();
    check(n, 8'h08);
    check({fifo_rdy_en, thresh_access}, 8'h02);
    wr(UAMC_OFS_IER, 8'h00);
    $display("done: write gating");
    wr(UAMC_OFS_MCR, 8'h10);
    idle(6);
    rd(UAMC_OFS_MSR, 8'h00, 8'hFF);
    wr(UAMC_OFS_MCR, 8'h1F);
    idle(6);
    rd(UAMC_OFS_MSR, 8'hFF, 8'hFF);
    rd(UAMC_OFS_MSR, 8'hF0, 8'hFF);
    check(pins, 8'h0E);
    wr(UAMC_OFS_MCR, 8'h10);
    idle(6);
    rd(UAMC_OFS_MSR, 8'h0B, 8'hFF);
    repeat (6)
    begin
      r = 4'($random(seed));
      wr(UAMC_OFS_MCR, {4'h1, r});
      idle(6);
      rd(UAMC_OFS_MSR, {r[3], r[2], r[0], r[1], 4'h0}, 8'hF0);
    end
    wr(UAMC_OFS_MCR, 8'h00);
    idle(6);
    rd(UAMC_OFS_MSR, 8'h00, 8'hF0);
    $display("done: loopback");
    lines(4'h1);
    rd(UAMC_OFS_MSR, 8'h11, 8'hFF);
    lines(4'h5);
    rd(UAMC_OFS_MSR, 8'h54, 8'hFF);
    lines(4'h1);
    rd(UAMC_OFS_MSR, 8'h10, 8'hFF);
    lines(4'hA);
    rd(UAMC_OFS_MSR, 8'hAB, 8'hFF);
    lines(4'h0);
    rd(UAMC_OFS_MSR, 8'h0A, 8'hFF);
    $display("done: modem lines");
    fifo_enable = 1'b1;
    wr(UAMC_OFS_IER, 8'h08);
    wr(UAMC_OFS_MCR, 8'h08);
    lines(4'h8);
    check({5'h00, irq, irq_oe, gen_out_n}, 8'h06);
    rd(UAMC_OFS_IIR, 8'hC0, 8'hFF);
    rd(UAMC_OFS_MSR, 8'h88, 8'hFF);
    check({5'h00, irq, irq_oe, gen_out_n}, 8'h02);
    wr(UAMC_OFS_MCR, 8'h00);
    lines(4'h0);
    check({5'h00, irq, irq_oe, gen_out_n}, 8'h01);
    rd(UAMC_OFS_MSR, 8'h08, 8'hFF);
    $display("done: modem interrupt");
    wr(UAMC_OFS_MCR, 8'h08);
    wr(UAMC_OFS_IER, 8'h0F);
    {lsr_error, rx_timeout, rx_ready, tx_space_ok} = 4'hF;
    idle(2);
    check({7'h00, irq}, 8'h01);
    rd(UAMC_OFS_IIR, 8'hC6, 8'hFF);
    lsr_error = 1'b0;
    rd(UAMC_OFS_IIR, 8'hCC, 8'hFF);
    rx_timeout = 1'b0;
    rd(UAMC_OFS_IIR, 8'hC4, 8'hFF);
    rx_ready = 1'b0;
    rd(UAMC_OFS_IIR, 8'hC2, 8'hFF);
    rd(UAMC_OFS_IIR, 8'hC1, 8'hFF);
    wr(UAMC_OFS_IER, 8'h0D);
    wr(UAMC_OFS_IER, 8'h0F);
    rd(UAMC_OFS_IIR, 8'hC1, 8'hFF);
    tx_space_ok = 1'b0;
    idle(2);
    tx_space_ok = 1'b1;
    idle(2);
    check({7'h00, irq}, 8'h01);
    tx_write = 1'b1;
    idle(1);
    tx_write = 1'b0;
    idle(1);
    rd(UAMC_OFS_IIR, 8'hC1, 8'hFF);
    rx_ready = 1'b1;
    wr(UAMC_OFS_IER, 8'h00);
    rd(UAMC_OFS_IIR, 8'hC1, 8'hFF);
    check({7'h00, irq}, 8'h00);
    rx_ready = 1'b0;
    $display("done: priority");
    wr(UAMC_OFS_IER, 8'h20);
    xoff_seen = 1'b1;
    idle(1);
    xoff_seen = 1'b0;
    idle(1);
    rd(UAMC_OFS_IIR, 8'hD0, 8'hFF);
    rd(UAMC_OFS_IIR, 8'hC1, 8'hFF);
    wr(UAMC_OFS_IER, 8'h40);
    auto_rts_en = 1'b1;
    auto_rts_n = 1'b0;
    idle(2);
    check({7'h00, rts_n}, 8'h00);
    auto_rts_n = 1'b1;
    idle(2);
    rd(UAMC_OFS_IIR, 8'hE0, 8'hFF);
    rd(UAMC_OFS_IIR, 8'hC1, 8'hFF);
    wr(UAMC_OFS_IIR, 8'hFF);
    rd(UAMC_OFS_IIR, 8'hC1, 8'hFF);
    $display("done: xoff and change");
    idle(3);
    end_of_test();
  end
endmodule : uart_modem_ctrl_irq_tb
